// >>> dv/cpo_cfg_model.sv
// Model of the configuring device: init line, data clock and capture.
`timescale 1ns/1ps
`default_nettype none
module cpo_cfg_model
  import cpo_pkg::*;
(
  input wire logic clock,
  input wire logic go,
  input wire logic [8:0] rises,
  input wire logic [3:0] half,
  input wire logic init_low,
  input wire cpo_pkg::cpo_odpin_s oe_reset_n_pin,
  input wire cpo_pkg::cpo_dbus_s dbus,
  output logic oe_reset_n_in,
  output logic configuration_clock,
  output logic busy
);
  logic [WORD_W-1:0] cap [$];
  logic clk_reg = 1'b0;
  logic busy_reg = 1'b0;
  logic [8:0] left_reg = 9'h000;
  logic [3:0] phase_reg = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // The wire has a pull-up, so it is low while either party pulls it.
  assign oe_reset_n_in = ~oe_reset_n_pin.oe & ~init_low;
  assign configuration_clock = clk_reg;
  assign busy = busy_reg;

  ////////////////////////////////////////////////////////////////////////////
  // The clock stands low between frames; data is taken at each rise.
  // Floating pins read as the pull-up level, never as the last value.
  always @(posedge clock) begin
    if (go && !busy_reg) begin
      busy_reg <= 1'b1;
      left_reg <= rises;
      phase_reg <= 4'h0;
    end else if (busy_reg) begin
      if (phase_reg != half) begin
        phase_reg <= phase_reg + 4'h1;
      end else begin
        phase_reg <= 4'h0;
        if (!clk_reg && left_reg != 9'h000) begin
          clk_reg <= 1'b1;
          left_reg <= left_reg - 9'h001;
          cap.push_back((dbus.data & dbus.oe) | ~dbus.oe);
        end else if (clk_reg) begin
          clk_reg <= 1'b0;
        end else begin
          busy_reg <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the configuration PROM output control.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("Error %s expected %h seen %h", nm, exp, got); \
    end \
  end
module tb;
  import cpo_pkg::*;
  localparam int HOLD = 20;
  localparam int LIMIT = 10000;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic supply_low = 1'b0;
  logic chip_enable_n = 1'b1;
  logic go = 1'b0;
  logic init_low = 1'b0;
  logic [8:0] rises = 9'h000;
  logic [3:0] half = 4'h3;
  cpo_prog_s prog = '0;
  logic oe_reset_n_in, configuration_clock, busy;
  cpo_odpin_s oe_reset_n_pin;
  cpo_dbus_s dbus;
  logic chip_enable_out_n, standby, icc_reduced;
  logic [WORD_W-1:0] words [ARRAY_DEPTH];
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;

  cpo_top #(.POR_HOLD_CYCLES(HOLD)) DUT (.clock(clock), .rst(rst),
    .supply_low(supply_low), .oe_reset_n_in(oe_reset_n_in),
    .chip_enable_n(chip_enable_n),
    .configuration_clock(configuration_clock), .prog(prog),
    .oe_reset_n_pin(oe_reset_n_pin), .dbus(dbus),
    .chip_enable_out_n(chip_enable_out_n), .standby(standby),
    .icc_reduced(icc_reduced));
  cpo_cfg_model M (.clock(clock), .go(go), .rises(rises), .half(half),
    .init_low(init_low), .oe_reset_n_pin(oe_reset_n_pin), .dbus(dbus),
    .oe_reset_n_in(oe_reset_n_in),
    .configuration_clock(configuration_clock), .busy(busy));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; a hang counts as a mismatch.
  initial begin
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_total++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (err_total == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Checks happen mid-cycle so that edge updates have landed.
  task automatic settle();
    @(negedge clock);
  endtask
  // One frame of n rises; a long half period stalls the prefetch buffer.
  task automatic frame(input int n, input logic [3:0] h);
    int guard;
    guard = 0;
    M.cap.delete();
    @(posedge clock);
    go <= 1'b1;
    rises <= 9'(n);
    half <= h;
    @(posedge clock);
    go <= 1'b0;
    settle();
    while (busy && guard < 5000) begin
      settle();
      guard++;
    end
  endtask
  // Serial words leave MSB first on pin 0, other pins float high.
  task automatic check_stream(input int n, input logic par);
    logic [7:0] exp;
    for (int i = 0; i < n; i++) begin
      exp = par ? words[i] : {7'h7f, words[i / 8][7 - i % 8]};
      `CHK("stream", exp, M.cap[i])
    end
  endtask
  task automatic wait_release();
    int guard;
    guard = 0;
    while (oe_reset_n_pin.oe !== 1'b0 && guard < 100) begin
      settle();
      guard++;
    end
    tick(8);
  endtask
  // A new configuration pulses the init line low.
  task automatic restart();
    @(posedge clock);
    init_low <= 1'b1;
    tick(3);
    init_low <= 1'b0;
    tick(8);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_power_up();
    int n;
    n = 0;
    settle();
    `CHK("init_wire", 1'b0, oe_reset_n_in)
    `CHK("pull_level", 1'b0, oe_reset_n_pin.out)
    `CHK("float_rst", OE_OFF, dbus.oe)
    while (oe_reset_n_pin.oe === 1'b1 && n < 100) begin
      settle();
      n++;
    end
    `CHK("hold_len", 1'b1, n >= HOLD && n <= HOLD + 2)
    // A mode write before any array write must be ignored.
    @(posedge clock);
    prog <= {1'b0, 1'b1, 4'h0, 8'h00, 1'b1};
    for (int i = 0; i < ARRAY_DEPTH; i++) begin
      @(posedge clock);
      prog <= {1'b1, 1'b0, 4'(i), words[i], 1'b0};
    end
    @(posedge clock);
    prog <= '0;
  endtask
  task automatic t_serial();
    @(posedge clock);
    chip_enable_n <= 1'b0;
    tick(8);
    settle();
    `CHK("cascade_active", 1'b1, chip_enable_out_n)
    `CHK("oe_serial", OE_SERIAL, dbus.oe)
    frame(130, 4'h3);
    check_stream(128, 1'b0);
    `CHK("past_end", 8'hff, M.cap[128])
    `CHK("cascade_handoff", 1'b0, chip_enable_out_n)
    `CHK("icc_low", 1'b1, icc_reduced)
  endtask
  task automatic t_oe_reset();
    @(posedge clock);
    init_low <= 1'b1;
    tick(3);
    settle();
    `CHK("cascade_reset", 1'b1, chip_enable_out_n)
    `CHK("float_reset", OE_OFF, dbus.oe)
    @(posedge clock);
    init_low <= 1'b0;
    tick(8);
    frame(20, 4'h3);
    check_stream(20, 1'b0);
    restart();
    frame(8, 4'h9);
    check_stream(8, 1'b0);
  endtask
  task automatic t_standby();
    @(posedge clock);
    chip_enable_n <= 1'b1;
    tick(3);
    settle();
    `CHK("standby", 1'b1, standby)
    `CHK("float_ce", OE_OFF, dbus.oe)
    frame(4, 4'h3);
    `CHK("float_ce_clk", 8'hff, M.cap[3])
    @(posedge clock);
    chip_enable_n <= 1'b0;
    tick(8);
    settle();
    `CHK("awake", 1'b0, standby)
    frame(8, 4'h3);
    check_stream(8, 1'b0);
  endtask
  task automatic t_parallel();
    @(posedge clock);
    init_low <= 1'b1;
    prog <= {1'b0, 1'b1, 4'h0, 8'h00, 1'b1};
    @(posedge clock);
    prog <= '0;
    tick(2);
    init_low <= 1'b0;
    tick(8);
    settle();
    `CHK("oe_par", OE_PARALLEL, dbus.oe)
    frame(17, 4'h3);
    check_stream(16, 1'b1);
    `CHK("par_past_end", 8'hff, M.cap[16])
    `CHK("par_cascade", 1'b0, chip_enable_out_n)
  endtask
  task automatic t_supply();
    restart();
    frame(5, 4'h3);
    @(posedge clock);
    supply_low <= 1'b1;
    tick(2);
    settle();
    `CHK("brown_pull", 1'b1, oe_reset_n_pin.oe)
    `CHK("brown_float", OE_OFF, dbus.oe)
    `CHK("brown_cascade", 1'b1, chip_enable_out_n)
    @(posedge clock);
    supply_low <= 1'b0;
    tick(2);
    settle();
    `CHK("rehold", 1'b1, oe_reset_n_pin.oe)
    wait_release();
    frame(3, 4'h3);
    check_stream(3, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    for (int i = 0; i < ARRAY_DEPTH; i++) begin
      words[i] = 8'(i * 29 + 60);
    end
    tick(8);
    rst <= 1'b0;
    t_power_up();
    t_serial();
    t_oe_reset();
    t_standby();
    t_parallel();
    t_supply();
    finish_test();
  end
endmodule
`default_nettype wire

// >>> rtl/cpo_buf2.sv
// Small FIFO that carries prefetched array words to the output stage.
`timescale 1ns/1ps
`default_nettype none
module cpo_buf2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  logic [WIDTH-1:0] entry_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  logic push;
  logic pop;

  // Pointer step with wrap at the last entry.
  function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p);
    return (p == PTR_LAST) ? '0 : PTR_W'(p + 1'b1);
  endfunction

  // Full and empty come from the occupancy count, never from guesses.
  assign in_ready = (count_reg != CNT_FULL);
  assign out_valid = (count_reg != '0);
  assign out_data = entry_reg[rd_ptr_reg];
  assign push = in_valid && in_ready && !flush;
  assign pop = out_valid && out_ready && !flush;

  // Storage is written only on an accepted push.
  always_ff @(posedge clock) begin
    if (push) begin
      entry_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and count; a flush empties the buffer in one cycle.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ptr_step(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= ptr_step(rd_ptr_reg);
      end
      if (push && !pop) begin
        count_reg <= CNT_W'(count_reg + 1'b1);
      end else if (pop && !push) begin
        count_reg <= CNT_W'(count_reg - 1'b1);
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/cpo_pkg.sv
// Constants, types and helpers shared by the configuration PROM output logic.
`default_nettype none
package cpo_pkg;

  // Array shape: words of stored data and bits per word.
  localparam int ARRAY_DEPTH = 16;
  localparam int WORD_W = 8;
  localparam int UNIT_MAX = ARRAY_DEPTH * WORD_W;
  localparam int ADDR_W = $clog2(UNIT_MAX);
  localparam int WIDX_W = $clog2(ARRAY_DEPTH);
  localparam int BIT_W = $clog2(WORD_W);

  // Counter reset values and the terminal count of each output mode.
  localparam logic [ADDR_W-1:0] ADDR_RST = '0;
  localparam logic [WIDX_W-1:0] WIDX_RST = '0;
  localparam logic [WIDX_W-1:0] WIDX_LAST = WIDX_W'(ARRAY_DEPTH - 1);
  localparam logic [ADDR_W-1:0] ADDR_ONE = ADDR_W'(1);
  localparam logic [BIT_W-1:0] BIT_FIRST = BIT_W'(WORD_W - 1);
  localparam logic [BIT_W-1:0] BIT_LAST = '0;
  localparam logic [BIT_W-1:0] BIT_ONE = BIT_W'(1);
  localparam logic [ADDR_W-1:0] ADDR_LAST_SERIAL = ADDR_W'(UNIT_MAX - 1);
  localparam logic [ADDR_W-1:0] ADDR_LAST_PARALLEL = ADDR_W'(ARRAY_DEPTH - 1);

  // Output enable patterns for the data pins.
  localparam logic [WORD_W-1:0] OE_PARALLEL = 8'hff;
  localparam logic [WORD_W-1:0] OE_SERIAL = 8'h01;
  localparam logic [WORD_W-1:0] OE_OFF = 8'h00;
  localparam logic [WORD_W-1:0] WORD_ZERO = 8'h00;

  // Power-up hold of the output-enable/reset line.
  localparam int POR_HOLD_NS = 1000000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int POR_HOLD_CYCLES_DFLT =
    (POR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [31:0] POR_CNT_RST = 32'h0000_0000;

  // Prefetch buffer depth.
  localparam int BUF_DEPTH = 2;

  // Data pins: level and output enable per pin.
  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic [WORD_W-1:0] oe;
  } cpo_dbus_s;

  // Open-drain pin driver: level driven and its enable.
  typedef struct packed {
    logic out;
    logic oe;
  } cpo_odpin_s;

  // Programming port: array word write and customer control write.
  typedef struct packed {
    logic array_we;
    logic ctrl_we;
    logic [WIDX_W-1:0] addr;
    logic [WORD_W-1:0] data;
    logic parallel;
  } cpo_prog_s;

  // Terminal count for the selected output mode.
  function automatic logic [ADDR_W-1:0] cpo_addr_last(input logic parallel);
    return parallel ? ADDR_LAST_PARALLEL : ADDR_LAST_SERIAL;
  endfunction

endpackage
`default_nettype wire

// >>> rtl/cpo_top.sv
// Output control and address counter of a configuration PROM.
// Operation
// - Hold output-enable/reset low about 1 ms
// - Supply below 2.0V forces full reset
// - Output-enable/reset is fixed active low
// - Chip enable high means standby
// - Chip enable high holds address reset
// - Chip enable high keeps data floating
// - Enabled below terminal count: count, drive, cascade high
// - Past terminal count: freeze, float, cascade low
// - Either control inactive: reset, float, cascade high
// - Terminal count is highest address, wraps zero
// - Advance counters on each configuration clock rise; the code does not count a rise that finds no word loaded
// - Byte per clock parallel, bit serial default
// - Downstream part drives when its enable falls
`timescale 1ns/1ps
`default_nettype none
module cpo_top #(
  parameter int POR_HOLD_CYCLES = cpo_pkg::POR_HOLD_CYCLES_DFLT
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic supply_low,
  input wire logic oe_reset_n_in,
  input wire logic chip_enable_n,
  input wire logic configuration_clock,
  input wire cpo_pkg::cpo_prog_s prog,
  output var cpo_pkg::cpo_odpin_s oe_reset_n_pin,
  output var cpo_pkg::cpo_dbus_s dbus,
  output logic chip_enable_out_n,
  output logic standby,
  output logic icc_reduced
);
  import cpo_pkg::*;

  localparam logic [31:0] POR_LAST = 32'(POR_HOLD_CYCLES - 1);

  logic [WORD_W-1:0] mem_reg [ARRAY_DEPTH];
  logic programmed_reg;
  logic parallel_reg;
  logic [31:0] por_cnt_reg;
  logic por_busy_reg;
  logic cfg_clk_prev_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic past_end_reg;
  logic [WIDX_W-1:0] fetch_idx_reg;
  logic fetch_done_reg;
  logic [WORD_W-1:0] cur_word_reg;
  logic cur_valid_reg;
  logic [BIT_W-1:0] bit_idx_reg;
  logic active;
  logic cfg_clk_rise;
  logic step;
  logic consume;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_pop;
  logic [WORD_W-1:0] buf_out_data;
  logic show;

  //////////////////////////////////////////////////////////////////////////
  // Control decode.

  // The reset line is read as active low with no inversion option.
  assign active = oe_reset_n_in && !chip_enable_n
    && !supply_low;
  assign cfg_clk_rise = configuration_clock && !cfg_clk_prev_reg;
  // A clock edge with no word loaded is an underrun and is not counted.
  assign step = active && cfg_clk_rise && !past_end_reg
    && cur_valid_reg;
  assign consume = step
    && (parallel_reg || (bit_idx_reg == BIT_LAST));
  assign buf_pop = buf_out_valid && (!cur_valid_reg || consume);
  assign show = active && !past_end_reg && cur_valid_reg;

  //////////////////////////////////////////////////////////////////////////
  // Array storage and customer control bits.

  // The array is nonvolatile, so neither reset clears it.
  always_ff @(posedge clock) begin
    if (prog.array_we) begin
      mem_reg[prog.addr] <= prog.data;
    end
  end

  // Mode bit is taken only once the array holds data; serial by default.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      programmed_reg <= 1'b0;
      parallel_reg <= 1'b0;
    end else begin
      if (prog.array_we) begin
        programmed_reg <= 1'b1;
      end
      if (prog.ctrl_we && programmed_reg) begin
        parallel_reg <= prog.parallel;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Power-up hold of the output-enable/reset line.

  // A supply dip restarts the hold, as a fresh power-up would.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      por_cnt_reg <= POR_CNT_RST;
      por_busy_reg <= 1'b1;
    end else if (supply_low) begin
      por_cnt_reg <= POR_CNT_RST;
      por_busy_reg <= 1'b1;
    end else if (por_busy_reg) begin
      por_cnt_reg <= 32'(por_cnt_reg + 1'b1);
      if (por_cnt_reg == POR_LAST) begin
        por_busy_reg <= 1'b0;
      end
    end
  end

  // Open-drain driver: pulls low only while the hold lasts.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      oe_reset_n_pin <= '{out: 1'b0, oe: 1'b1};
    end else begin
      oe_reset_n_pin <= '{out: 1'b0, oe: por_busy_reg || supply_low};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Address counter and terminal count.

  // Edge detector on the configuration clock level.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_clk_prev_reg <= 1'b0;
    end else begin
      cfg_clk_prev_reg <= configuration_clock;
    end
  end

  // Counting stops after the wrap to zero until the controls go inactive.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addr_reg <= ADDR_RST;
      past_end_reg <= 1'b0;
    end else if (!active) begin
      addr_reg <= ADDR_RST;
      past_end_reg <= 1'b0;
    end else if (step) begin
      if (addr_reg == cpo_addr_last(parallel_reg)) begin
        addr_reg <= ADDR_RST;
        past_end_reg <= 1'b1;
      end else begin
        addr_reg <= ADDR_W'(addr_reg + ADDR_ONE);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Prefetch into the buffer.

  // Words are read ahead so each clock edge from the third active cycle on finds its data waiting.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fetch_idx_reg <= WIDX_RST;
      fetch_done_reg <= 1'b0;
    end else if (!active) begin
      fetch_idx_reg <= WIDX_RST;
      fetch_done_reg <= 1'b0;
    end else if (!fetch_done_reg && buf_in_ready) begin
      fetch_idx_reg <= WIDX_W'(fetch_idx_reg + 1'b1);
      fetch_done_reg <= (fetch_idx_reg == WIDX_LAST);
    end
  end

  cpo_buf2 #(
    .WIDTH(WORD_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clock(clock),
    .rst(rst),
    .flush(!active),
    .in_valid(active && !fetch_done_reg),
    .in_ready(buf_in_ready),
    .in_data(mem_reg[fetch_idx_reg]),
    .out_valid(buf_out_valid),
    .out_ready(buf_pop),
    .out_data(buf_out_data)
  );

  //////////////////////////////////////////////////////////////////////////
  // Output word and bit position.

  // Serial mode shifts out the most significant bit first.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cur_word_reg <= WORD_ZERO;
      cur_valid_reg <= 1'b0;
      bit_idx_reg <= BIT_FIRST;
    end else if (!active) begin
      cur_valid_reg <= 1'b0;
      bit_idx_reg <= BIT_FIRST;
    end else begin
      if (buf_pop) begin
        cur_word_reg <= buf_out_data;
        cur_valid_reg <= 1'b1;
      end else if (consume) begin
        cur_valid_reg <= 1'b0;
      end
      if (step && !parallel_reg) begin
        bit_idx_reg <= (bit_idx_reg == BIT_LAST) ? BIT_FIRST :
                       BIT_W'(bit_idx_reg - BIT_ONE);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registered pins: no enable glitches reach the shared cascade bus.

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dbus <= '{data: WORD_ZERO, oe: OE_OFF};
      chip_enable_out_n <= 1'b1;
      standby <= 1'b0;
      icc_reduced <= 1'b0;
    end else begin
      dbus.data <= parallel_reg ? cur_word_reg :
                   {{(WORD_W-1){1'b0}}, cur_word_reg[bit_idx_reg]};
      dbus.oe <= !show ? OE_OFF :
                 (parallel_reg ? OE_PARALLEL : OE_SERIAL);
      chip_enable_out_n <= !(active && past_end_reg);
      standby <= chip_enable_n;
      icc_reduced <= active && past_end_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks.

  por_hold_a: assert property (@(posedge clock)
    $fell(rst) |-> (oe_reset_n_pin.oe && !oe_reset_n_pin.out) [*8])
    else $error("reset line released too early");
  supply_reset_a: assert property (@(posedge clock) disable iff (rst)
    supply_low |=> addr_reg == ADDR_RST && dbus.oe == OE_OFF
      && chip_enable_out_n && oe_reset_n_pin.oe)
    else $error("supply dip did not reset the block");
  standby_on_a: assert property (@(posedge clock) disable iff (rst)
    chip_enable_n |=> standby && !icc_reduced)
    else $error("standby not entered");
  addr_ce_a: assert property (@(posedge clock) disable iff (rst)
    chip_enable_n |=> addr_reg == ADDR_RST)
    else $error("address not held with enable high");
  float_ce_a: assert property (@(posedge clock) disable iff (rst)
    chip_enable_n ##1 chip_enable_n |=> dbus.oe == OE_OFF)
    else $error("data driven with enable high");
  count_up_a: assert property (@(posedge clock) disable iff (rst)
    step && addr_reg != cpo_addr_last(parallel_reg) && !prog.ctrl_we
      |=> addr_reg == ADDR_W'($past(addr_reg) + ADDR_ONE) && !past_end_reg)
    else $error("address did not advance");
  stop_end_a: assert property (@(posedge clock) disable iff (rst)
    active && past_end_reg |=> !chip_enable_out_n && dbus.oe == OE_OFF
      && icc_reduced && $stable(addr_reg))
    else $error("wrong behaviour past terminal count");
  inactive_a: assert property (@(posedge clock) disable iff (rst)
    !oe_reset_n_in |=> addr_reg == ADDR_RST && chip_enable_out_n
      && dbus.oe == OE_OFF)
    else $error("inactive controls not honoured");
  count_wrap_a: assert property (@(posedge clock) disable iff (rst)
    step && addr_reg == cpo_addr_last(parallel_reg) && !prog.ctrl_we
      |=> addr_reg == ADDR_RST && past_end_reg)
    else $error("terminal count wrap wrong");
  out_width_a: assert property (@(posedge clock) disable iff (rst)
    dbus.oe != OE_OFF |-> dbus.oe == (parallel_reg ? OE_PARALLEL : OE_SERIAL))
    else $error("data width does not match mode");

  stream_end_c: cover property (@(posedge clock) disable iff (rst)
    active && $rose(past_end_reg));
  standby_c: cover property (@(posedge clock) disable iff (rst)
    $rose(standby));
  buf_full_c: cover property (@(posedge clock) disable iff (rst)
    active && !buf_in_ready);
  parallel_c: cover property (@(posedge clock) disable iff (rst)
    parallel_reg && step);
endmodule
`default_nettype wire
